// ==== inc/pad_pkg.sv ====
/*
 * Constants and types for the platform address decoder: region bounds,
 * populated sizes, size codes, slave selects and core mode encoding.
 * Assumes one platform clock and a 24-bit byte address.
 */
package pad_pkg;

    localparam int ADDR_W = 24;          // Byte address width
    localparam int DATA_W = 32;          // Data path width

    // Region bases and upper bounds
    localparam logic [23:0] FLASH_BASE = 24'h00_0000;
    localparam logic [23:0] FLASH_TOP  = 24'h7F_FFFF;
    localparam logic [23:0] RAM_BASE   = 24'h80_0000;
    localparam logic [23:0] RAM_TOP    = 24'hBF_FFFF;
    localparam logic [23:0] GPIO_BASE  = 24'hC0_0000;
    localparam logic [23:0] GPIO_TOP   = 24'hDF_FFFF;
    localparam logic [23:0] RSV_BASE   = 24'hE0_0000;
    localparam logic [23:0] RSV_TOP    = 24'hFF_7FFF;
    localparam logic [23:0] PERI_BASE  = 24'hFF_8000;
    localparam logic [23:0] PERI_TOP   = 24'hFF_FFFF;
    localparam logic [23:0] INTC_BASE  = 24'hFF_FFC0;

    // Default populated sizes in bytes
    localparam logic [23:0] FLASH_SIZE_DEF = 24'h02_0000;
    localparam logic [23:0] RAM_SIZE_DEF   = 24'h00_2000;
    localparam logic [23:0] GPIO_SIZE_DEF  = 24'h20_0000;

    // Reference size encoding
    typedef enum logic [1:0] {
        PAD_SZ_BYTE = 2'h0,
        PAD_SZ_WORD = 2'h1,
        PAD_SZ_LONG = 2'h2,
        PAD_SZ_RSV  = 2'h3
    } pad_size_t;

    // Slave selection
    typedef enum logic [2:0] {
        PAD_SEL_NONE,
        PAD_SEL_FLASH,
        PAD_SEL_RAM,
        PAD_SEL_GPIO,
        PAD_SEL_PERI
    } pad_sel_t;

    // Core mode
    typedef enum logic [1:0] {
        PAD_MODE_RUN,
        PAD_MODE_STOP,
        PAD_MODE_HALT
    } pad_mode_t;

    localparam int PERI_RATIO_DEF = 2;  // Platform:peripheral clock ratio

endpackage : pad_pkg

// ==== rtl/pad_region_decode.sv ====
/*
 * Combinational region decoder: maps a 24-bit address, direction and
 * size onto one slave select and an error flag.
 * Assumes the caller registers the result at its own pipeline stage.
 */
`timescale 1ns/1ps

module pad_region_decode
    import pad_pkg::*;
#(
    parameter logic [23:0] FLASH_SIZE = FLASH_SIZE_DEF,
    parameter logic [23:0] RAM_SIZE   = RAM_SIZE_DEF,
    parameter logic [23:0] GPIO_SIZE  = GPIO_SIZE_DEF
)
(
    input  wire logic [23:0]      addr_i,   // Byte address
    input  wire logic             write_i,  // High for write
    input  wire pad_pkg::pad_size_t size_i, // Reference size
    output pad_pkg::pad_sel_t     sel_o,    // Chosen slave
    output logic                  err_o     // Hole, reserved or bad size
);

    ////////////////////////////////////////////////////////////////////
    // Region hits
    wire in_flash = (addr_i <= FLASH_TOP);
    wire in_ram   = (addr_i >= RAM_BASE)  && (addr_i <= RAM_TOP);
    wire in_gpio  = (addr_i >= GPIO_BASE) && (addr_i <= GPIO_TOP);
    wire in_rsv   = (addr_i >= RSV_BASE)  && (addr_i <= RSV_TOP);
    wire in_peri  = (addr_i >= PERI_BASE);

    // Populated part starts at region base; rest is a hole
    wire hole_f = in_flash && ((addr_i - FLASH_BASE) >= FLASH_SIZE);
    wire hole_r = in_ram   && ((addr_i - RAM_BASE)   >= RAM_SIZE);
    wire hole_g = in_gpio  && ((addr_i - GPIO_BASE)  >= GPIO_SIZE);

    // Size legality per region
    wire sz_rsv  = (size_i == PAD_SZ_RSV);
    wire bad_f   = sz_rsv || (write_i && size_i != PAD_SZ_LONG);
    wire bad_rg  = sz_rsv;
    wire bad_p   = sz_rsv || (size_i == PAD_SZ_LONG);

    wire bad_sz  = (in_flash && bad_f) || ((in_ram || in_gpio) && bad_rg)
                 || (in_peri && bad_p);

    assign err_o = in_rsv || hole_f || hole_r || hole_g || bad_sz;

    // Select only when access is legal
    assign sel_o = err_o   ? PAD_SEL_NONE  :
                   in_flash ? PAD_SEL_FLASH :
                   in_ram   ? PAD_SEL_RAM   :
                   in_gpio  ? PAD_SEL_GPIO  :
                   in_peri  ? PAD_SEL_PERI  : PAD_SEL_NONE;

endmodule : pad_region_decode

// ==== rtl/pad_local_bus_ctrl.sv ====
/*
 * Local bus controller: takes master requests in the address phase,
 * steers them to flash, RAM, fast GPIO or the peripheral bridge, and
 * error-terminates illegal cycles itself in the data phase. Includes a
 * simple n:1 peripheral bridge with optional buffered writes and the
 * core mode status flags.
 * Assumes one platform clock; the peripheral side samples its strobe on
 * the enable pulse produced here; slaves hold ready low to wait.
 */
`timescale 1ns/1ps

// Operation
// - Decode 24-bit byte address, 16 MB space
// - Flash region 0x000000 to 0x7FFFFF
// - RAM region 0x800000 to 0xBFFFFF
// - Fast GPIO region 0xC00000 to 0xDFFFFF
// - Reserved range selects no slave
// - Peripheral bridge region 0xFF8000 to 0xFFFFFF
// - Unpopulated hole access gets error termination
// - Flash: any read size, longword writes only
// - RAM and GPIO accept all sizes
// - Peripheral: byte and word only
// - Illegal size terminated with error
// - Address phase then data phase pipeline
// - Ready low stalls both pipeline stages
// - Peripheral bus single-cycle, not pipelined
// - Masters start transactions at controller input
// - Interrupt controller at top 64 bytes
// - Peripheral clock ratio n:1
// - Programmable buffered peripheral writes
// - Core mode on stop and halt flags
module pad_local_bus_ctrl
    import pad_pkg::*;
#(
    parameter int          PERI_RATIO = PERI_RATIO_DEF,  // n of n:1
    parameter logic [23:0] FLASH_SIZE = FLASH_SIZE_DEF,
    parameter logic [23:0] RAM_SIZE   = RAM_SIZE_DEF,
    parameter logic [23:0] GPIO_SIZE  = GPIO_SIZE_DEF
)
(
    input  wire logic                 clk_i,
    input  wire logic                 rstn_i,
    // Master side, address and data phase
    input  wire logic                 m_req_i,       // Request valid
    input  wire logic [31:0]          m_addr_i,      // Upper byte ignored
    input  wire logic                 m_write_i,
    input  wire pad_pkg::pad_size_t   m_size_i,
    input  wire logic [31:0]          m_wdata_i,     // Data-phase write data
    output logic                      m_ready_o,     // Data-phase termination
    output logic                      m_err_o,       // Error termination
    output logic [31:0]               m_rdata_o,
    // Platform slaves, shared request
    output logic                      flash_sel_o,
    output logic                      ram_sel_o,
    output logic                      gpio_sel_o,
    output logic [23:0]               s_addr_o,
    output logic                      s_write_o,
    output pad_pkg::pad_size_t        s_size_o,
    input  wire logic                 s_ready_i,     // Selected slave ready
    input  wire logic [31:0]          s_rdata_i,
    // Peripheral bus
    output logic                      p_en_o,        // Peripheral clock enable
    output logic                      p_sel_o,
    output logic [23:0]               p_addr_o,
    output logic                      p_write_o,
    output pad_pkg::pad_size_t        p_size_o,
    output logic [31:0]               p_wdata_o,
    input  wire logic [31:0]          p_rdata_i,
    input  wire logic                 p_err_i,
    input  wire logic                 buf_wr_en_i,   // Buffered write enable
    // Core mode
    input  wire pad_pkg::pad_mode_t   core_mode_i,
    output logic                      core_stop_flag_o,
    output logic                      core_halt_flag_o
);

    ////////////////////////////////////////////////////////////////////
    // Decode of the address phase
    // Flat compares only: address-phase critical path
    wire [ADDR_W-1:0] addr_a = m_addr_i[ADDR_W-1:0];  // Bits above 23 unused
    pad_sel_t         dec_sel;                          // Decoder select
    logic             dec_err;                          // Decoder error

    // Decoder sized to the populated memories
    pad_region_decode #(
        .FLASH_SIZE (FLASH_SIZE),
        .RAM_SIZE   (RAM_SIZE),
        .GPIO_SIZE  (GPIO_SIZE)
    ) u_dec (
        .addr_i  (addr_a),
        .write_i (m_write_i),
        .size_i  (m_size_i),
        .sel_o   (dec_sel),
        .err_o   (dec_err)
    );

    ////////////////////////////////////////////////////////////////////
    // Peripheral enable divider
    // Counter width; ratio 1 still keeps one bit
    localparam int PCW = (PERI_RATIO > 1) ? $clog2(PERI_RATIO) : 1;
    localparam logic [PCW-1:0] PDIV_LAST = PCW'(PERI_RATIO - 1);
    logic [PCW-1:0] pdiv_r;                             // Divider count
    wire            p_tick = (pdiv_r == PDIV_LAST);     // Peripheral edge

    // Free-running divider; ratio 1 ticks every cycle
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            pdiv_r <= '0;
        else
            pdiv_r <= p_tick ? '0 : pdiv_r + PCW'(1);
    end

    ////////////////////////////////////////////////////////////////////
    // Data-phase state
    typedef enum logic [1:0] {
        PAD_DP_IDLE,     // No cycle in data phase
        PAD_DP_SLAVE,    // Waiting on platform slave
        PAD_DP_PERI,     // Waiting on peripheral strobe
        PAD_DP_ERR       // Local error termination
    } pad_dp_t;

    pad_dp_t     dp_r, dp_nxt;
    logic        p_busy_r;          // Peripheral access in flight
    logic        p_done_r;          // Peripheral beat seen this period
    logic [31:0] p_rdata_r;         // Captured peripheral read data

    // Data phase completes when its termination is given
    // Idle and local-error states free the pipe at once
    wire dp_done = (dp_r == PAD_DP_IDLE) ||
                   (dp_r == PAD_DP_ERR) ||
                   ((dp_r == PAD_DP_SLAVE) && s_ready_i) ||
                   ((dp_r == PAD_DP_PERI) && p_done_r);

    // Peripheral request waits while a buffered write runs
    wire peri_block = (dec_sel == PAD_SEL_PERI) && p_busy_r;

    // Early answers (error, buffered write) would merge with a
    // slave or bridge termination given at the same edge
    wire quick_ans  = dec_err || ((dec_sel == PAD_SEL_PERI) && m_write_i && buf_wr_en_i);
    wire term_now   = (dp_r == PAD_DP_SLAVE) || (dp_r == PAD_DP_PERI);

    // New address phase advances only when data phase ends
    wire take = m_req_i && dp_done && !peri_block && !(quick_ans && term_now);

    // Buffered peripheral write terminates at once; bridge finishes it later.
    // Trade-off: a later peripheral error on a buffered write is lost.
    wire peri_take  = take && (dec_sel == PAD_SEL_PERI);
    // At most one buffered write outstanding
    wire buf_write  = peri_take && m_write_i && buf_wr_en_i && !p_busy_r;

    // Next data-phase state
    always_comb
    begin
        // Default: hold while a slave waits
        dp_nxt = dp_r;
        if (dp_done)
        begin
            if (!take)
                dp_nxt = PAD_DP_IDLE;
            else if (dec_err)
                dp_nxt = PAD_DP_ERR;
            else if (dec_sel == PAD_SEL_PERI && !buf_write)
                dp_nxt = PAD_DP_PERI;
            else if (dec_sel == PAD_SEL_PERI)
                dp_nxt = PAD_DP_IDLE;
            else
                dp_nxt = PAD_DP_SLAVE;
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            dp_r <= PAD_DP_IDLE;
        else
            dp_r <= dp_nxt;
    end

    ////////////////////////////////////////////////////////////////////
    // Platform slave request, held while stalled
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            // Nothing selected out of reset
            flash_sel_o <= 1'b0;
            ram_sel_o   <= 1'b0;
            gpio_sel_o  <= 1'b0;
            s_addr_o    <= '0;
            s_write_o   <= 1'b0;
            s_size_o    <= PAD_SZ_BYTE;
        end
        else if (dp_done)                                        // Stall holds
        begin
            // Errored cycles are never forwarded
            // Attributes copy through even when idle
            flash_sel_o <= take && dec_sel == PAD_SEL_FLASH;
            ram_sel_o   <= take && dec_sel == PAD_SEL_RAM;
            gpio_sel_o  <= take && dec_sel == PAD_SEL_GPIO;
            s_addr_o    <= addr_a;
            s_write_o   <= m_write_i;
            s_size_o    <= m_size_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Peripheral bus: one beat on a peripheral edge, write data loaded a cycle after the other fields
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            // Bridge idle out of reset
            p_busy_r  <= 1'b0;
            p_done_r  <= 1'b0;
            p_sel_o   <= 1'b0;
            p_addr_o  <= '0;
            p_write_o <= 1'b0;
            p_size_o  <= PAD_SZ_BYTE;
            p_wdata_o <= '0;
            p_rdata_r <= '0;
            p_en_o    <= 1'b0;
        end
        else
        begin
            // Enable pulse runs free, also between beats
            p_en_o   <= p_tick;
            p_done_r <= 1'b0;
            // Start a beat only when the bridge is free
            if (peri_take && !dec_err && !p_busy_r)
            begin
                p_busy_r  <= 1'b1;
                p_sel_o   <= 1'b1;
                p_addr_o  <= addr_a;
                p_write_o <= m_write_i;
                p_size_o  <= m_size_i;
            end
            else if (p_busy_r && p_tick)
            begin
                // Beat ends on the peripheral edge, no pipelining
                p_busy_r  <= 1'b0;
                p_sel_o   <= 1'b0;
                p_rdata_r <= p_rdata_i;
                p_done_r  <= (dp_r == PAD_DP_PERI);
            end
            // Write data follows one cycle behind, in master data phase
            if (p_busy_r && p_write_o && !p_done_r)
                p_wdata_o <= m_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Master termination and read data
    logic pend_err_r;   // Peripheral error to report
    // Sampled on the same peripheral edge as read data
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            pend_err_r <= 1'b0;
        else if (p_busy_r && p_tick)
            pend_err_r <= p_err_i;
    end

    // Registered answer; ready marks end of data phase
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            m_ready_o <= 1'b0;
            m_err_o   <= 1'b0;
            m_rdata_o <= '0;
        end
        else
        begin
            // Error, buffered write, slave ready or bridge done;
            // a slave ends its cycle even if the next follows at once
            m_ready_o <= (dp_nxt == PAD_DP_ERR)
                      || (dp_nxt == PAD_DP_IDLE && buf_write)
                      || (dp_r == PAD_DP_SLAVE && s_ready_i)
                      || (dp_r == PAD_DP_PERI && p_done_r);
            m_err_o   <= (dp_nxt == PAD_DP_ERR)
                      || (dp_r == PAD_DP_PERI && p_done_r && pend_err_r);
            m_rdata_o <= (dp_r == PAD_DP_PERI) ? p_rdata_r : s_rdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Core mode flags
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            core_stop_flag_o <= 1'b0;
            core_halt_flag_o <= 1'b0;
        end
        else
        begin
            // Unused encoding reads as running
            core_stop_flag_o <= (core_mode_i == PAD_MODE_STOP);
            core_halt_flag_o <= (core_mode_i == PAD_MODE_HALT);
        end
    end

endmodule : pad_local_bus_ctrl

// ==== tb/pad_bus_ctrl_sva.sv ====
/* Port checker for the local bus controller.
   Assumes one-cycle request pulses issued while the data phase is idle. */
`timescale 1ns/1ps

module pad_bus_ctrl_sva
    import pad_pkg::*;
#(
    parameter int          PERI_RATIO = PERI_RATIO_DEF,
    parameter logic [23:0] FLASH_SIZE = FLASH_SIZE_DEF,
    parameter logic [23:0] RAM_SIZE   = RAM_SIZE_DEF,
    parameter logic [23:0] GPIO_SIZE  = GPIO_SIZE_DEF
)
(
    input wire logic                clk_i,
    input wire logic                rstn_i,
    input wire logic                m_req_i,
    input wire logic [31:0]         m_addr_i,
    input wire logic                m_write_i,
    input wire pad_pkg::pad_size_t  m_size_i,
    input wire logic                m_ready_o,
    input wire logic                m_err_o,
    input wire logic                flash_sel_o,
    input wire logic                ram_sel_o,
    input wire logic                gpio_sel_o,
    input wire logic [23:0]         s_addr_o,
    input wire logic                s_ready_i,
    input wire logic                p_sel_o,
    input wire pad_pkg::pad_mode_t  core_mode_i,
    input wire logic                core_stop_flag_o,
    input wire logic                core_halt_flag_o
);
    localparam int PMAX = PERI_RATIO + 3;  // Bridge answer bound
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    ////////////////////////////////////////////////////////////////////////
    // Expected legality, upper byte dropped
    wire logic [23:0] a_w  = m_addr_i[23:0];
    wire logic        sz_w = m_size_i != PAD_SZ_RSV;
    wire logic ok_f = a_w < FLASH_SIZE && sz_w && (!m_write_i || m_size_i == PAD_SZ_LONG);
    wire logic ok_r = a_w >= RAM_BASE && a_w - RAM_BASE < RAM_SIZE && sz_w;
    wire logic ok_g = a_w >= GPIO_BASE && a_w - GPIO_BASE < GPIO_SIZE && sz_w;
    wire logic ok_p = a_w >= PERI_BASE && (m_size_i == PAD_SZ_BYTE || m_size_i == PAD_SZ_WORD);
    wire logic any_sel = flash_sel_o | ram_sel_o | gpio_sel_o;

    sequence take_s;
        $rose(m_req_i);
    endsequence
    sequence stall_s;
        any_sel && !s_ready_i;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    a_err_has_ready: assert property (m_err_o |-> m_ready_o)
        else $error("error flag without termination");
    a_bad_errs: assert property (take_s ##0 !(ok_f | ok_r | ok_g | ok_p) |=>
        m_ready_o && m_err_o && !any_sel && !p_sel_o) else $error("illegal access not refused");
    a_flash_route: assert property (take_s ##0 ok_f |=>
        flash_sel_o && !ram_sel_o && s_addr_o == $past(a_w)) else $error("flash not selected");
    a_ram_route: assert property (take_s ##0 ok_r |=>
        ram_sel_o && !gpio_sel_o && s_addr_o == $past(a_w)) else $error("ram not selected");
    a_gpio_route: assert property (take_s ##0 ok_g |=>
        gpio_sel_o && !flash_sel_o) else $error("gpio not selected");
    a_wait_stall: assert property (stall_s |=> !m_ready_o && any_sel && $stable(s_addr_o))
        else $error("wait state not honoured");
    a_slave_done: assert property (any_sel && s_ready_i |=> m_ready_o && !m_err_o)
        else $error("slave ready not forwarded");
    a_peri_answer: assert property (take_s ##0 ok_p |-> ##[1:PMAX] m_ready_o)
        else $error("peripheral access not answered");
    a_stop_flag: assert property ((rstn_i && core_mode_i == PAD_MODE_STOP)[*2] |->
        core_stop_flag_o && !core_halt_flag_o) else $error("stop flags wrong");
    a_halt_flag: assert property ((rstn_i && core_mode_i == PAD_MODE_HALT)[*2] |->
        core_halt_flag_o && !core_stop_flag_o) else $error("halt flags wrong");
endmodule : pad_bus_ctrl_sva

bind pad_local_bus_ctrl pad_bus_ctrl_sva #(.PERI_RATIO(PERI_RATIO), .FLASH_SIZE(FLASH_SIZE),
    .RAM_SIZE(RAM_SIZE), .GPIO_SIZE(GPIO_SIZE)) sva_u (.clk_i(clk_i), .rstn_i(rstn_i),
    .m_req_i(m_req_i), .m_addr_i(m_addr_i), .m_write_i(m_write_i), .m_size_i(m_size_i),
    .m_ready_o(m_ready_o), .m_err_o(m_err_o), .flash_sel_o(flash_sel_o), .ram_sel_o(ram_sel_o),
    .gpio_sel_o(gpio_sel_o), .s_addr_o(s_addr_o), .s_ready_i(s_ready_i), .p_sel_o(p_sel_o),
    .core_mode_i(core_mode_i), .core_stop_flag_o(core_stop_flag_o), .core_halt_flag_o(core_halt_flag_o));

// ==== tb/pad_slave_model.sv ====
/* Behavioural platform slaves and peripheral bus slave.
   Assumes selects are registered by the controller. */
`timescale 1ns/1ps

module pad_slave_model
(
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        any_sel_i,  // Some platform slave selected
    input  wire logic [23:0] s_addr_i,
    input  wire logic        p_sel_i,
    input  wire logic [23:0] p_addr_i,
    input  wire logic [3:0]  wait_i,     // Wait states to insert
    input  wire logic        err_en_i,   // Commanded peripheral error
    output logic             s_ready_o,
    output logic [31:0]      s_rdata_o,
    output logic [31:0]      p_rdata_o,
    output logic             p_err_o
);
    logic [3:0]  wait_r;  // Cycles spent in data phase
    logic [31:0] junk_r;  // Changing pattern for undriven data

    // Count wait states; restart per access
    always_ff @(posedge clk_i)
    begin
        wait_r <= (!rstn_i || !any_sel_i || s_ready_o) ? 4'h0 : wait_r + 4'h1;
        junk_r <= rstn_i ? junk_r + 32'h1357_9BDF : 32'h5A5A_A5A5;
    end

    // Ready held low to stall both stages
    assign s_ready_o = any_sel_i && (wait_r >= wait_i);
    assign s_rdata_o = s_ready_o ? {8'hC3, s_addr_i} : junk_r;
    // Peripheral answers within its cycle
    assign p_rdata_o = p_sel_i ? {8'h3C, p_addr_i} : junk_r;
    assign p_err_o   = p_sel_i ? err_en_i : junk_r[0];
endmodule : pad_slave_model

// ==== tb/pad_local_bus_ctrl_tb.sv ====
/* Self-checking bench for the local bus controller.
   Assumes the slave model answers all platform and peripheral slaves. */
`timescale 1ns/1ps

`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp); end end

module pad_local_bus_ctrl_tb;
    import pad_pkg::*;

    typedef struct {logic [31:0] addr; logic wr; pad_size_t sz; logic err; logic [2:0] sel; logic peri;} pad_row_t;

    logic clk_i = 1'b0, rstn_i = 1'b0, m_req_i = 1'b0, m_write_i = 1'b0, buf_wr_en_i = 1'b0;
    logic [31:0] m_addr_i = 32'h0, m_wdata_i = 32'h0, m_rdata_o, s_rdata_i, p_rdata_i, p_wdata_o;
    logic [23:0] s_addr_o, p_addr_o;
    pad_size_t   m_size_i = PAD_SZ_BYTE, s_size_o, p_size_o;
    pad_mode_t   core_mode_i = PAD_MODE_HALT;  // Flags must still read 0 in reset
    logic m_ready_o, m_err_o, flash_sel_o, ram_sel_o, gpio_sel_o, s_write_o, s_ready_i;
    logic p_en_o, p_sel_o, p_write_o, p_err_i, core_stop_flag_o, core_halt_flag_o;
    logic [3:0]  wait_v = 4'h0;
    logic        err_v = 1'b0, err_q;
    logic [2:0]  sel_q;
    logic [31:0] rd_q;
    int mismatches = 0, check_count = 0, n, cnt;

    // Flash hole at 0x02_0000, RAM hole at 0x80_2000
    pad_row_t rows[18] = '{
        '{32'h0000_0010, 0, PAD_SZ_BYTE, 0, 3'h4, 0}, '{32'h0001_FFFC, 0, PAD_SZ_LONG, 0, 3'h4, 0},
        '{32'h0000_0100, 1, PAD_SZ_LONG, 0, 3'h4, 0}, '{32'h0000_0100, 1, PAD_SZ_BYTE, 1, 3'h0, 0},
        '{32'h0000_0102, 1, PAD_SZ_WORD, 1, 3'h0, 0}, '{32'h0002_0000, 0, PAD_SZ_LONG, 1, 3'h0, 0},
        '{32'h0080_0000, 1, PAD_SZ_BYTE, 0, 3'h2, 0}, '{32'hAB80_1FFE, 0, PAD_SZ_WORD, 0, 3'h2, 0},
        '{32'h0080_2000, 0, PAD_SZ_BYTE, 1, 3'h0, 0}, '{32'h0080_0004, 0, PAD_SZ_RSV,  1, 3'h0, 0},
        '{32'h00C0_0000, 1, PAD_SZ_LONG, 0, 3'h1, 0}, '{32'h00DF_FFFC, 0, PAD_SZ_LONG, 0, 3'h1, 0},
        '{32'h00E0_0000, 0, PAD_SZ_BYTE, 1, 3'h0, 0}, '{32'h00FF_7FFF, 1, PAD_SZ_BYTE, 1, 3'h0, 0},
        '{32'h00FF_8000, 0, PAD_SZ_BYTE, 0, 3'h0, 1}, '{32'h00FF_8004, 1, PAD_SZ_LONG, 1, 3'h0, 1},
        '{32'h00FF_FFC0, 1, PAD_SZ_WORD, 0, 3'h0, 1}, '{32'h00FF_FFFE, 0, PAD_SZ_WORD, 0, 3'h0, 1}};

    ////////////////////////////////////////////////////////////////////////
    pad_local_bus_ctrl #(.PERI_RATIO(3)) dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .m_req_i(m_req_i),
        .m_addr_i(m_addr_i), .m_write_i(m_write_i), .m_size_i(m_size_i), .m_wdata_i(m_wdata_i),
        .m_ready_o(m_ready_o), .m_err_o(m_err_o), .m_rdata_o(m_rdata_o), .flash_sel_o(flash_sel_o),
        .ram_sel_o(ram_sel_o), .gpio_sel_o(gpio_sel_o), .s_addr_o(s_addr_o), .s_write_o(s_write_o),
        .s_size_o(s_size_o), .s_ready_i(s_ready_i), .s_rdata_i(s_rdata_i), .p_en_o(p_en_o),
        .p_sel_o(p_sel_o), .p_addr_o(p_addr_o), .p_write_o(p_write_o), .p_size_o(p_size_o),
        .p_wdata_o(p_wdata_o), .p_rdata_i(p_rdata_i), .p_err_i(p_err_i), .buf_wr_en_i(buf_wr_en_i),
        .core_mode_i(core_mode_i), .core_stop_flag_o(core_stop_flag_o), .core_halt_flag_o(core_halt_flag_o));

    pad_slave_model slv_u (.clk_i(clk_i), .rstn_i(rstn_i), .any_sel_i(flash_sel_o | ram_sel_o | gpio_sel_o),
        .s_addr_i(s_addr_o), .p_sel_i(p_sel_o), .p_addr_i(p_addr_o), .wait_i(wait_v), .err_en_i(err_v),
        .s_ready_o(s_ready_i), .s_rdata_o(s_rdata_i), .p_rdata_o(p_rdata_i), .p_err_o(p_err_i));

    always #25 clk_i = ~clk_i;  // 20 MHz

    ////////////////////////////////////////////////////////////////////////
    // One request pulse, then a bounded wait for termination
    task automatic issue(input logic [31:0] a, input logic wr, input pad_size_t sz);
        @(posedge clk_i);
        m_req_i <= 1'b1; m_addr_i <= a; m_write_i <= wr; m_size_i <= sz; m_wdata_i <= ~a;
        @(posedge clk_i);
        m_req_i <= 1'b0;
        #1 sel_q = {flash_sel_o, ram_sel_o, gpio_sel_o};
        for (n = 0; m_ready_o !== 1'b1 && n < 20; n++) @(posedge clk_i) #1;
        if (n == 20) mismatches++;
        err_q = m_err_o;
        rd_q = m_rdata_o;
    endtask : issue

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict

    // Watchdog, far above the expected few hundred cycles
    initial
    begin
        #200000;
        mismatches++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk_i);
        #1 `CHK({m_ready_o, any_sel(), p_sel_o, core_stop_flag_o, core_halt_flag_o}, 5'h0)
        @(posedge clk_i) rstn_i <= 1'b1;
        // Table of ordinary accesses
        foreach (rows[i])
        begin
            issue(rows[i].addr, rows[i].wr, rows[i].sz);
            `CHK(sel_q, rows[i].sel)
            `CHK(err_q, rows[i].err)
            if (rows[i].err) `CHK(n, 0)
            else if (!rows[i].wr) `CHK(rd_q, {rows[i].peri ? 8'h3C : 8'hC3, rows[i].addr[23:0]})
            if (rows[i].sel != 3'h0) `CHK({s_write_o, s_size_o}, {rows[i].wr, rows[i].sz})
        end
        // Slow slave: three wait states
        wait_v = 4'h3;
        issue(32'h0080_0010, 1'b0, PAD_SZ_LONG);
        `CHK(n, 4)
        wait_v = 4'h0;
        // Back-to-back RAM reads, one termination each
        @(posedge clk_i) m_req_i <= 1'b1;
        m_addr_i <= 32'h0080_0040;
        @(posedge clk_i) m_addr_i <= 32'h0080_0044;
        @(posedge clk_i) m_req_i <= 1'b0;
        #1 `CHK({m_ready_o, m_rdata_o}, {1'b1, 8'hC3, 24'h80_0040})
        @(posedge clk_i) #1 `CHK({m_ready_o, m_rdata_o}, {1'b1, 8'hC3, 24'h80_0044})
        // Peripheral error passed back
        err_v = 1'b1;
        issue(32'h00FF_8004, 1'b0, PAD_SZ_WORD);
        `CHK(err_q, 1'b1)
        err_v = 1'b0;
        // Buffered write ends at once
        @(posedge clk_i) buf_wr_en_i <= 1'b1;
        issue(32'h00FF_8010, 1'b1, PAD_SZ_WORD);
        `CHK(n, 0)
        cnt = 0;
        repeat (30) @(posedge clk_i) #1 cnt += p_en_o;
        `CHK(cnt, 10)
        `CHK({p_wdata_o, p_addr_o, p_write_o, p_size_o}, {~32'h00FF_8010, 24'hFF_8010, 1'b1, PAD_SZ_WORD})
        buf_wr_en_i <= 1'b0;
        // Mode flags for every mode
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk_i) core_mode_i <= pad_mode_t'(i);
            repeat (2) @(posedge clk_i);
            #1 `CHK({core_stop_flag_o, core_halt_flag_o}, {1'(i == 1), 1'(i == 2)})
        end
        // Reset in mid-run, then request at once
        @(posedge clk_i) rstn_i <= 1'b0;
        @(posedge clk_i) #1 `CHK({m_ready_o, any_sel(), p_sel_o, core_stop_flag_o, core_halt_flag_o}, 5'h0)
        rstn_i <= 1'b1;
        issue(32'h0080_0020, 1'b0, PAD_SZ_BYTE);
        `CHK(sel_q, 3'h2)
        print_verdict();
    end

    function automatic logic any_sel();
        return flash_sel_o | ram_sel_o | gpio_sel_o;
    endfunction : any_sel
endmodule : pad_local_bus_ctrl_tb
